// [bench/host_model.sv]
module host_model (
  input wire logic clk,
  input wire logic [7:0] host_data_out,
  input wire logic host_wait_ready,
  output logic [7:0] host_data_in,
  output logic access_select_hi,
  output logic access_select_lo,
  output logic byte_half_select,
  output logic host_read_write,
  output logic data_strobe_one_n,
  output logic data_strobe_two_n,
  output logic addr_latch_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // A single-strobe host with separate buses: the second strobe and the latch strobe stay high.
  initial begin
    host_data_in = 8'h00;
    access_select_hi = 1'b0;
    access_select_lo = 1'b0;
    byte_half_select = 1'b0;
    host_read_write = 1'b1;
    data_strobe_one_n = 1'b1;
    data_strobe_two_n = 1'b1;
    addr_latch_strobe_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One byte access. The strobe is held until ready has fallen and risen again.
  task automatic xfer(input logic [1:0] sel, input logic half, input logic rd,
                      input logic [7:0] wd, output logic [7:0] got, output int waits);
    int n;
    n = 0;
    waits = 0;
    @(posedge clk);
    {access_select_hi, access_select_lo} <= sel;
    byte_half_select <= half;
    host_read_write <= rd;
    host_data_in <= wd;
    data_strobe_one_n <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (host_wait_ready === 1'b1 && n < 20);
    while (host_wait_ready !== 1'b1 && waits < 20) begin
      waits++;
      @(posedge clk);
    end
    got = host_data_out;
    data_strobe_one_n <= 1'b1;
    // A released bus must not look as if it still held the last byte.
    host_data_in <= ~wd;
    repeat (4) @(posedge clk);
  endtask
endmodule

// [bench/tb.sv]
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst_n, ce, cpu_we, cpu_re, cpu_stall, cpu_irq;
  logic [11:0] cpu_addr;
  logic [15:0] cpu_wdata, cpu_rdata, d;
  logic [7:0] hdi, hdo, g;
  logic oe_n, rdy, irq_n, shi, slo, bhs, hrw, ds1_n, ds2_n, als_n;
  int fail_count, comparisons, w;
  localparam logic [11:0] CTRL = 12'h800;
  localparam logic [11:0] STAT = 12'h801;
  localparam logic [11:0] CLR = 12'h802;
  localparam logic [11:0] ENA = 12'h803;

  host_port u_host_port (.clk(clk), .rst_n(rst_n), .ce(ce), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_we(cpu_we), .cpu_re(cpu_re), .cpu_rdata(cpu_rdata),
    .cpu_stall(cpu_stall), .cpu_irq(cpu_irq), .host_data_in(hdi), .host_data_out(hdo),
    .host_data_oe_n(oe_n), .access_select_hi(shi), .access_select_lo(slo),
    .byte_half_select(bhs), .host_read_write(hrw), .data_strobe_one_n(ds1_n),
    .data_strobe_two_n(ds2_n), .addr_latch_strobe_n(als_n), .host_wait_ready(rdy),
    .host_irq_out_n(irq_n));

  host_model host (.clk(clk), .host_data_out(hdo), .host_wait_ready(rdy), .host_data_in(hdi),
    .access_select_hi(shi), .access_select_lo(slo), .byte_half_select(bhs),
    .host_read_write(hrw), .data_strobe_one_n(ds1_n), .data_strobe_two_n(ds2_n),
    .addr_latch_strobe_n(als_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cpu_wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= v;
    cpu_we <= 1'b1;
    @(posedge clk);
    cpu_we <= 1'b0;
    // Let the registers settle after the write edge before anyone looks at them.
    #1;
  endtask

  task automatic cpu_rd(input logic [11:0] a, output logic [15:0] v);
    @(posedge clk);
    cpu_addr <= a;
    cpu_re <= 1'b1;
    @(posedge clk);
    cpu_re <= 1'b0;
    #1 v = cpu_rdata;
  endtask

  task automatic set_addr(input logic [10:0] a);
    host.xfer(2'b10, 1'b0, 1'b0, {5'h00, a[10:8]}, g, w);
    host.xfer(2'b10, 1'b1, 1'b0, a[7:0], g, w);
  endtask

  task automatic stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("ready", 1'b1, rdy)
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("cpu_irq", 1'b0, cpu_irq)
  endtask

  // The address must not move between the two halves of one word.
  task automatic t_host_write;
    set_addr(11'h123);
    host.xfer(2'b01, 1'b0, 1'b0, 8'ha5, g, w);
    `CHK("sam waits", host_port_pkg::SAM_BYTE_PERIODS, w)
    host.xfer(2'b01, 1'b1, 1'b0, 8'h5a, g, w);
    host.xfer(2'b01, 1'b0, 1'b0, 8'h12, g, w);
    host.xfer(2'b01, 1'b1, 1'b0, 8'h34, g, w);
    cpu_rd(12'h123, d);
    `CHK("word0", 16'ha55a, d)
    cpu_rd(12'h124, d);
    `CHK("word1", 16'h1234, d)
  endtask

  task automatic t_host_read;
    logic oe_seen;
    oe_seen = 1'b1;
    cpu_wr(12'h3c5, 16'hbeef);
    set_addr(11'h3c5);
    host.xfer(2'b10, 1'b0, 1'b1, 8'h00, g, w);
    `CHK("addr hi", 8'h03, g)
    host.xfer(2'b10, 1'b1, 1'b1, 8'h00, g, w);
    `CHK("addr lo", 8'hc5, g)
    fork
      host.xfer(2'b11, 1'b0, 1'b1, 8'h00, g, w);
      begin
        repeat (6) @(posedge clk);
        #1 oe_seen = oe_n;
      end
    join
    `CHK("rd hi", 8'hbe, g)
    `CHK("oe on read", 1'b0, oe_seen)
    host.xfer(2'b11, 1'b1, 1'b1, 8'h00, g, w);
    `CHK("rd lo", 8'hef, g)
    host.xfer(2'b11, 1'b0, 1'b1, 8'h00, g, w);
    `CHK("no inc", 8'hbe, g)
  endtask

  task automatic t_irq;
    cpu_wr(ENA, 16'h0001);
    `CHK("masked", 1'b0, cpu_irq)
    host.xfer(2'b00, 1'b1, 1'b0, 8'h02, g, w);
    `CHK("doorbell", 1'b1, cpu_irq)
    cpu_wr(STAT, 16'hffff);
    cpu_rd(STAT, d);
    `CHK("status", 16'h0003, d)
    cpu_wr(CLR, 16'h0007);
    cpu_rd(STAT, d);
    `CHK("cleared", 16'h0000, d)
    `CHK("irq off", 1'b0, cpu_irq)
    cpu_rd(12'h805, d);
    `CHK("unmapped", 16'h0000, d)
  endtask

  task automatic t_host_irq;
    cpu_wr(CTRL, 16'h0004);
    `CHK("hirq set", 1'b0, irq_n)
    host.xfer(2'b00, 1'b1, 1'b1, 8'h00, g, w);
    `CHK("ctrl host", 8'h04, g)
    host.xfer(2'b00, 1'b1, 1'b0, 8'h04, g, w);
    `CHK("hirq clr", 1'b1, irq_n)
  endtask

  // The CPU reads every cycle, skipping the cycle after a stall, while the host fetches a word.
  task automatic t_collision;
    int stalls;
    logic skip;
    stalls = 0;
    skip = 1'b0;
    cpu_addr <= 12'h3c5;
    fork
      host.xfer(2'b11, 1'b0, 1'b1, 8'h00, g, w);
      repeat (14) begin
        @(posedge clk);
        cpu_re <= !skip;
        #1 skip = (cpu_stall === 1'b1);
        stalls += skip;
      end
    join
    cpu_re <= 1'b0;
    `CHK("host wins", 8'hbe, g)
    `CHK("stalls", 1, stalls)
    cpu_rd(STAT, d);
    `CHK("coll ev", 1'b1, d[host_port_pkg::EV_COLLISION])
    cpu_wr(CLR, 16'h0007);
  endtask

  task automatic t_mode;
    cpu_wr(CTRL, 16'h0001);
    set_addr(11'h010);
    `CHK("hom waits", host_port_pkg::HOM_BYTE_CYCLES, w)
    host.xfer(2'b01, 1'b0, 1'b0, 8'h5a, g, w);
    host.xfer(2'b01, 1'b1, 1'b0, 8'ha5, g, w);
    cpu_rd(12'h010, d);
    `CHK("cpu shut", 16'h0000, d)
    host.xfer(2'b00, 1'b1, 1'b1, 8'h00, g, w);
    `CHK("mode bit", 8'h01, g)
    host.xfer(2'b00, 1'b1, 1'b0, 8'h00, g, w);
    cpu_rd(12'h010, d);
    `CHK("shared", 16'h5aa5, d)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 100);
    fail_count++;
    stop_test;
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    cpu_we = 1'b0;
    cpu_re = 1'b0;
    cpu_addr = 12'h000;
    cpu_wdata = 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_host_write;
    t_host_read;
    t_irq;
    t_host_irq;
    t_collision;
    t_mode;
    stop_test;
  end
endmodule

// [inc/host_port_pkg.sv]
package host_port_pkg;

  // Device clock period and the byte pacing in each mode.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAM_BYTE_PERIODS = 5;
  localparam int HOM_BYTE_NS = 50;
  localparam int HOM_BYTE_CYCLES =
    (HOM_BYTE_NS / CLK_PERIOD_NS < 1) ? 1 : HOM_BYTE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int RAM_ADDR_W = 11;

  // Register indices inside the register region of the CPU port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h2;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h3;
  localparam int REG_IDX_W = 4;

  // Fields of the control register.
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_DOORBELL_BIT = 1;
  localparam int CTRL_HOST_IRQ_BIT = 2;
  localparam logic CTRL_MODE_RESET = 1'b0;

  // Event bits of the interrupt status register.
  localparam int EV_DOORBELL = 0;
  localparam int EV_HOST_WORD = 1;
  localparam int EV_COLLISION = 2;
  localparam int EV_W = 3;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'b00,
    SEL_DATA_INC = 2'b01,
    SEL_ADDR = 2'b10,
    SEL_DATA = 2'b11
  } access_sel_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SERVE = 2'b01,
    ST_HOLD = 2'b10
  } port_state_e;

  typedef struct packed {
    logic ds1_n;
    logic ds2_n;
    logic as_n;
    logic [1:0] sel;
    logic bhs;
    logic rw;
    logic [7:0] data;
  } host_pins_s;

  typedef struct packed {
    access_sel_e sel;
    logic bhs;
    logic rw;
  } host_ctl_s;

  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cpu_req_s;

endpackage

// [verilog/host_port.sv]
// The register offsets and strobed register access were left to the implementer.
module host_port #(
  parameter int ADDR_W = host_port_pkg::RAM_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_we,
  input wire logic cpu_re,
  output logic [15:0] cpu_rdata,
  output logic cpu_stall,
  output logic cpu_irq,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  input wire logic access_select_hi,
  input wire logic access_select_lo,
  input wire logic byte_half_select,
  input wire logic host_read_write,
  input wire logic data_strobe_one_n,
  input wire logic data_strobe_two_n,
  input wire logic addr_latch_strobe_n,
  output logic host_wait_ready,
  output logic host_irq_out_n
);

  // The address register splits at the byte boundary, so the buffer needs more than 8 bits.
  if (ADDR_W <= host_port_pkg::BYTE_W || ADDR_W > 15) begin : g_bad_width
    $error("host_port: ADDR_W must lie between 9 and 15");
  end

  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic low);
    byte_of = low ? w[7:0] : w[15:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host pin synchroniser. Every pin passes two flops before use.

  host_port_pkg::host_pins_s raw;
  host_port_pkg::host_pins_s sync1_ff;
  host_port_pkg::host_pins_s sync2_ff;
  logic prev_as_n_ff;

  assign raw = '{ds1_n: data_strobe_one_n, ds2_n: data_strobe_two_n,
                 as_n: addr_latch_strobe_n, sel: {access_select_hi, access_select_lo},
                 bhs: byte_half_select, rw: host_read_write, data: host_data_in};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= '{ds1_n: 1'b1, ds2_n: 1'b1, as_n: 1'b1, default: '0};
      sync2_ff <= '{ds1_n: 1'b1, ds2_n: 1'b1, as_n: 1'b1, default: '0};
      prev_as_n_ff <= 1'b1;
    end else if (ce) begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
      prev_as_n_ff <= sync2_ff.as_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode.

  host_port_pkg::port_state_e state_ff;
  host_port_pkg::host_ctl_s latched_ff;
  host_port_pkg::host_ctl_s ctl;
  host_port_pkg::host_ctl_s pin_ctl;
  host_port_pkg::cpu_req_s pend_ff;
  logic as_used_ff;
  logic strobe_act;
  logic start;
  logic is_data;
  logic host_ram_go;
  logic host_inc;
  logic mode_ff;
  logic [ADDR_W-1:0] host_addr_ff;
  logic [7:0] wr_hold_ff;
  logic [15:0] rd_latch_ff;
  logic [host_port_pkg::EV_W-1:0] status_ff;
  logic [host_port_pkg::EV_W-1:0] enable_ff;
  logic [host_port_pkg::EV_W-1:0] events;
  logic host_irq_ff;

  // One strobe active and the other idle qualifies an access; hosts with a
  // single strobe tie the second one high.
  assign strobe_act = sync2_ff.ds1_n ^ sync2_ff.ds2_n;
  assign start = strobe_act && (state_ff == host_port_pkg::ST_IDLE);
  assign pin_ctl = '{sel: host_port_pkg::access_sel_e'(sync2_ff.sel),
                     bhs: sync2_ff.bhs, rw: sync2_ff.rw};
  // Multiplexed hosts latch the selects with the address strobe.
  assign ctl = as_used_ff ? latched_ff : pin_ctl;
  assign is_data = (ctl.sel == host_port_pkg::SEL_DATA_INC) ||
                   (ctl.sel == host_port_pkg::SEL_DATA);
  // Reads fetch on the first byte, writes store on the second.
  assign host_ram_go = start && is_data && (ctl.rw ? !ctl.bhs : ctl.bhs);
  assign host_inc = start && (ctl.sel == host_port_pkg::SEL_DATA_INC) && ctl.bhs;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      as_used_ff <= 1'b0;
      latched_ff <= '{sel: host_port_pkg::SEL_CTRL, default: '0};
    end else if (ce) begin
      if (prev_as_n_ff && !sync2_ff.as_n) begin
        as_used_ff <= 1'b1;
        latched_ff <= pin_ctl;
      end else if (state_ff == host_port_pkg::ST_HOLD && !strobe_act) begin
        as_used_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host access sequencer and wait-state generation.

  logic [host_port_pkg::CNT_W-1:0] cnt_ff;
  logic [host_port_pkg::CNT_W-1:0] byte_len;
  logic host_rd_pend_ff;
  logic ready_ff;
  logic oe_n_ff;
  logic [7:0] data_out_ff;

  assign byte_len = mode_ff ? host_port_pkg::CNT_W'(host_port_pkg::HOM_BYTE_CYCLES)
                            : host_port_pkg::CNT_W'(host_port_pkg::SAM_BYTE_PERIODS);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= host_port_pkg::ST_IDLE;
      cnt_ff <= '0;
      ready_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else if (ce) begin
      case (state_ff)
        host_port_pkg::ST_IDLE: begin
          if (start) begin
            state_ff <= host_port_pkg::ST_SERVE;
            cnt_ff <= byte_len - 1'b1;
            ready_ff <= 1'b0;
            oe_n_ff <= !ctl.rw;
          end
        end
        host_port_pkg::ST_SERVE: begin
          if (cnt_ff == '0) begin
            state_ff <= host_port_pkg::ST_HOLD;
            ready_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        host_port_pkg::ST_HOLD: begin
          if (!strobe_act) begin
            state_ff <= host_port_pkg::ST_IDLE;
            oe_n_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= host_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Host-facing data path: address register, write byte hold, read latch.
  logic [15:0] ram_rdata;
  logic [15:0] ctrl_word;

  // Each bit is widened before the shift so that no tool shifts it out of a 1-bit operand.
  assign ctrl_word =
    (16'(host_irq_ff) << host_port_pkg::CTRL_HOST_IRQ_BIT) |
    (16'(status_ff[host_port_pkg::EV_DOORBELL]) << host_port_pkg::CTRL_DOORBELL_BIT) |
    (16'(mode_ff) << host_port_pkg::CTRL_MODE_BIT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_addr_ff <= '0;
      wr_hold_ff <= '0;
      rd_latch_ff <= '0;
      data_out_ff <= '0;
      host_rd_pend_ff <= 1'b0;
    end else if (ce) begin
      host_rd_pend_ff <= host_ram_go && ctl.rw;
      if (host_rd_pend_ff) begin
        rd_latch_ff <= ram_rdata;
        data_out_ff <= byte_of(ram_rdata, 1'b0);
      end
      if (start) begin
        if (ctl.sel == host_port_pkg::SEL_ADDR) begin
          if (ctl.rw) begin
            data_out_ff <= byte_of(16'(host_addr_ff), ctl.bhs);
          end else if (ctl.bhs) begin
            host_addr_ff[7:0] <= sync2_ff.data;
          end else begin
            host_addr_ff[ADDR_W-1:8] <= sync2_ff.data[ADDR_W-9:0];
          end
        end else if (ctl.sel == host_port_pkg::SEL_CTRL) begin
          if (ctl.rw) begin
            data_out_ff <= byte_of(ctrl_word, ctl.bhs);
          end
        end else if (ctl.rw && ctl.bhs) begin
          data_out_ff <= rd_latch_ff[7:0];
        end else if (!ctl.rw && !ctl.bhs) begin
          wr_hold_ff <= sync2_ff.data;
        end
      end
      if (host_inc) begin
        host_addr_ff <= host_addr_ff + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer arbitration. Host first, then a deferred CPU access, then a new one.

  logic cpu_buf;
  logic cpu_reg;
  logic pend_go;
  logic new_go;
  logic ram_en;
  logic ram_we;
  logic [ADDR_W-1:0] ram_addr;
  logic [15:0] ram_wdata;
  logic cpu_rsrc_ff;
  logic [15:0] reg_rdata_ff;

  assign cpu_buf = (cpu_we || cpu_re) && !cpu_addr[ADDR_W] && !mode_ff;
  assign cpu_reg = (cpu_we || cpu_re) && cpu_addr[ADDR_W];
  assign pend_go = pend_ff.valid && !host_ram_go;
  assign new_go = cpu_buf && !host_ram_go && !pend_ff.valid;
  assign cpu_stall = cpu_buf && !new_go;

  always_comb begin
    ram_en = host_ram_go || pend_go || new_go;
    if (host_ram_go) begin
      ram_we = !ctl.rw;
      ram_addr = host_addr_ff;
      ram_wdata = {wr_hold_ff, sync2_ff.data};
    end else if (pend_go) begin
      ram_we = pend_ff.we;
      ram_addr = pend_ff.addr[ADDR_W-1:0];
      ram_wdata = pend_ff.wdata;
    end else begin
      ram_we = cpu_we;
      ram_addr = cpu_addr[ADDR_W-1:0];
      ram_wdata = cpu_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else if (ce) begin
      if (cpu_stall) begin
        pend_ff <= '{valid: 1'b1, we: cpu_we, addr: 16'(cpu_addr[ADDR_W-1:0]),
                     wdata: cpu_wdata};
      end else if (pend_go) begin
        pend_ff.valid <= 1'b0;
      end
    end
  end

  host_port_ram #(
    .ADDR_W(ADDR_W),
    .DATA_W(host_port_pkg::WORD_W)
  ) u_ram (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .en(ram_en),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // CPU registers: control, interrupt status, clear and enable.

  logic cpu_wr_ctrl;
  logic host_wr_ctrl;

  assign cpu_wr_ctrl = cpu_reg && cpu_we &&
                       (cpu_addr[host_port_pkg::REG_IDX_W-1:0] == host_port_pkg::REG_CTRL);
  assign host_wr_ctrl = start && !ctl.rw && (ctl.sel == host_port_pkg::SEL_CTRL);
  assign events[host_port_pkg::EV_DOORBELL] =
    host_wr_ctrl && sync2_ff.data[host_port_pkg::CTRL_DOORBELL_BIT];
  assign events[host_port_pkg::EV_HOST_WORD] = host_ram_go && !ctl.rw;
  assign events[host_port_pkg::EV_COLLISION] = cpu_stall;
  assign cpu_irq = |(status_ff & enable_ff);
  assign host_irq_out_n = !host_irq_ff;
  assign host_wait_ready = ready_ff;
  assign host_data_oe_n = oe_n_ff;
  assign host_data_out = data_out_ff;
  // A buffer read and a register read landing in one cycle favour the buffer.
  assign cpu_rdata = cpu_rsrc_ff ? ram_rdata : reg_rdata_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= host_port_pkg::CTRL_MODE_RESET;
      host_irq_ff <= 1'b0;
    end else if (ce) begin
      if (host_wr_ctrl) begin
        mode_ff <= sync2_ff.data[host_port_pkg::CTRL_MODE_BIT];
      end else if (cpu_wr_ctrl) begin
        mode_ff <= cpu_wdata[host_port_pkg::CTRL_MODE_BIT];
      end
      // The CPU setting the host interrupt wins over a host clear.
      if (cpu_wr_ctrl && cpu_wdata[host_port_pkg::CTRL_HOST_IRQ_BIT]) begin
        host_irq_ff <= 1'b1;
      end else if (host_wr_ctrl && sync2_ff.data[host_port_pkg::CTRL_HOST_IRQ_BIT]) begin
        host_irq_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_ff <= '0;
      enable_ff <= '0;
    end else if (ce) begin
      if (cpu_reg && cpu_we &&
          cpu_addr[host_port_pkg::REG_IDX_W-1:0] == host_port_pkg::REG_IRQ_CLEAR) begin
        status_ff <= (status_ff & ~cpu_wdata[host_port_pkg::EV_W-1:0]) | events;
      end else begin
        status_ff <= status_ff | events;
      end
      if (cpu_reg && cpu_we &&
          cpu_addr[host_port_pkg::REG_IDX_W-1:0] == host_port_pkg::REG_IRQ_ENABLE) begin
        enable_ff <= cpu_wdata[host_port_pkg::EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= '0;
      cpu_rsrc_ff <= 1'b0;
    end else if (ce) begin
      cpu_rsrc_ff <= (pend_go && !pend_ff.we) || (new_go && !cpu_we);
      reg_rdata_ff <= '0;
      if (cpu_reg && cpu_re) begin
        if (cpu_addr[host_port_pkg::REG_IDX_W-1:0] == host_port_pkg::REG_CTRL) begin
          reg_rdata_ff <= ctrl_word;
        end else if (cpu_addr[host_port_pkg::REG_IDX_W-1:0] ==
                     host_port_pkg::REG_IRQ_STATUS) begin
          reg_rdata_ff <= 16'(status_ff);
        end else if (cpu_addr[host_port_pkg::REG_IDX_W-1:0] ==
                     host_port_pkg::REG_IRQ_ENABLE) begin
          reg_rdata_ff <= 16'(enable_ff);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !ce);

  logic start_sam;
  logic start_hom;
  assign start_sam = start && !mode_ff;
  assign start_hom = start && mode_ff;

  a_sam_byte_pace: assert property (start_sam |=> !host_wait_ready [*5] ##1 host_wait_ready)
    else $error("shared mode byte not served in five clocks");
  a_hom_byte_pace: assert property (start_hom |=> !host_wait_ready ##1 host_wait_ready)
    else $error("host only byte not served in one clock");
  a_incr_second_byte: assert property (host_inc |=> host_addr_ff == $past(host_addr_ff) + 1'b1)
    else $error("address not advanced after second byte");
  a_no_incr_first: assert property (start && is_data && !ctl.bhs |=>
                                    host_addr_ff == $past(host_addr_ff))
    else $error("address moved after first byte");
  a_collision_stall: assert property (host_ram_go && cpu_buf |-> cpu_stall ##1 pend_go)
    else $error("collision did not defer the CPU by one cycle");
  a_host_irq_set: assert property (cpu_wr_ctrl && cpu_wdata[host_port_pkg::CTRL_HOST_IRQ_BIT]
                                   |=> !host_irq_out_n)
    else $error("host interrupt not raised");
  a_doorbell_irq: assert property (events[host_port_pkg::EV_DOORBELL] &&
                                   enable_ff[host_port_pkg::EV_DOORBELL] |=> cpu_irq)
    else $error("doorbell did not interrupt the CPU");
  a_hom_cpu_block: assert property (mode_ff && !cpu_addr[ADDR_W] && (cpu_we || cpu_re)
                                    && !pend_ff.valid && !host_ram_go |-> !ram_en)
    else $error("CPU reached buffer in host only mode");
  a_drive_on_read: assert property (!host_data_oe_n |-> state_ff != host_port_pkg::ST_IDLE)
    else $error("data pins driven outside an access");
  a_ready_in_hold: assert property (state_ff == host_port_pkg::ST_HOLD |-> host_wait_ready)
    else $error("ready low while waiting for strobe release");

  c_sam_access: cover property (start_sam ##6 state_ff == host_port_pkg::ST_HOLD);
  c_hom_access: cover property (start_hom);
  c_collision: cover property (cpu_stall ##1 pend_go);
  c_word_written: cover property (events[host_port_pkg::EV_HOST_WORD]);

endmodule

// [verilog/host_port_ram.sv]
module host_port_ram #(
  parameter int ADDR_W = host_port_pkg::RAM_ADDR_W,
  parameter int DATA_W = host_port_pkg::WORD_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic en,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  // One port only: the owner of each cycle is chosen outside.
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (ce && en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce && en && !we) begin
      rdata <= mem[addr];
    end
  end

endmodule
